// [scg_pkg.sv]
// Constants, register map and types for the system clock select and gear block
package scg_pkg;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int WAIT_W = 15;

  // Register offsets
  localparam logic [3:0] REG_OSC_CTRL = 4'h0;  // Oscillator enables and rtc run bit
  localparam logic [3:0] REG_OSC_WAIT = 4'h1;  // Stabilization wait selects
  localparam logic [3:0] REG_CLK_SRC = 4'h2;   // Source select, variant, status
  localparam logic [3:0] REG_CORE_GEAR = 4'h3; // Core clock gear

  // Oscillator control field positions
  localparam int CTRL_IH_EN = 0;   // internal_high_osc_enable
  localparam int CTRL_XH_EN = 1;   // crystal_high_osc_enable
  localparam int CTRL_LOW_EN = 2;  // low_osc_enable
  localparam int CTRL_RTC_RUN = 3; // rtc_run_bit

  // Wait field positions (two bits each, low bit given)
  localparam int WAIT_IH_LSB = 0;   // internal_high_wait_sel
  localparam int WAIT_XH_LSB = 2;   // crystal_high_wait_sel
  localparam int WAIT_IL_LSB = 4;   // internal_low_wait_sel
  localparam int WAIT_XL_LSB = 6;   // crystal_low_wait_sel

  // Source register field positions
  localparam int SRC_SEL_LSB = 0;     // sys_clock_source_sel
  localparam int SRC_VARIANT = 2;     // low_osc_variant_sel
  localparam int SRC_ACTIVE_LSB = 3;  // Source the mux really uses (read only)
  localparam int SRC_RDY_IH = 5;      // Internal high ready (read only)
  localparam int SRC_RDY_XH = 6;      // Crystal high ready (read only)
  localparam int SRC_RDY_LOW = 7;     // Low speed ready (read only)

  // Source encodings
  localparam logic [1:0] SRC_INT_HIGH = 2'h0;
  localparam logic [1:0] SRC_LOW = 2'h1;
  localparam logic [1:0] SRC_XTAL_HIGH = 2'h2;
  localparam logic [1:0] SRC_RESERVED = 2'h3;

  // Reset values
  localparam logic RST_IH_EN = 1'b1;
  localparam logic RST_XH_EN = 1'b0;
  localparam logic RST_LOW_EN = 1'b0;
  localparam logic RST_RTC_RUN = 1'b0;
  localparam logic [7:0] RST_WAIT = 8'h00;
  localparam logic [1:0] RST_SRC = 2'h0;
  localparam logic RST_VARIANT = 1'b1;
  localparam logic [1:0] RST_GEAR = 2'h0;

  // Shortest wait of each oscillator (code 0x3), in oscillator cycles
  localparam logic [WAIT_W-1:0] XTAL_LOW_WAIT_MIN = 15'h0800;  // 2048
  localparam logic [WAIT_W-1:0] INT_LOW_WAIT_MIN = 15'h0008;   // 8
  localparam logic [WAIT_W-1:0] XTAL_HIGH_WAIT_MIN = 15'h0080; // 128
  localparam logic [WAIT_W-1:0] INT_HIGH_WAIT_MIN = 15'h0008;  // 8

  // Core clock state
  typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_SLEEP} scg_mode_t;

  // Wait count: code 0x3 is the base, each lower code doubles it
  function automatic logic [WAIT_W-1:0] wait_count(input logic [WAIT_W-1:0] base,
                                                   input logic [1:0] code);
    logic [WAIT_W-1:0] r;
    r = base;
    unique case (code)
      2'h3: r = base;
      2'h2: r = base << 1;
      2'h1: r = base << 2;
      2'h0: r = base << 3;
    endcase
    return r;
  endfunction : wait_count

  // Gear terminal count: divide by 1, 2, 4, 8
  function automatic logic [2:0] gear_mask(input logic [1:0] code);
    logic [2:0] r;
    r = 3'h0;
    unique case (code)
      2'h0: r = 3'h0;
      2'h1: r = 3'h1;
      2'h2: r = 3'h3;
      2'h3: r = 3'h7;
    endcase
    return r;
  endfunction : gear_mask

endpackage : scg_pkg

// [scg_osc_stab.sv]
// Oscillator pin synchroniser, edge detector and stabilization wait counter
`timescale 1ns/100ps
`default_nettype none
module scg_osc_stab #(
  parameter int CNT_W = 15  // Width of the wait counter
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst_n, // Asynchronous reset, active low
  input wire logic i_osc, // Raw oscillator pin, asynchronous
  input wire logic i_run, // Oscillator is switched on
  input wire logic [CNT_W-1:0] i_wait, // Cycles to wait after start
  output logic o_level, // Synchronised oscillator level
  output logic o_rise, // One-cycle pulse per rising edge
  output logic o_ready // Wait elapsed, clock may be used
);

  logic sync1_q; // First stage, read only by second stage
  logic sync2_q; // Second stage, safe to use
  logic prev_q; // Delayed copy for edge detection
  logic ready_q; // Wait elapsed
  logic [CNT_W-1:0] cnt_q; // Rising edges seen since start, held once ready

  // Two-flop synchroniser; oscillator must stay below half the system rate
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= i_osc;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Count oscillator edges after start; stopping clears the count
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      ready_q <= 1'b0;
    end else if (!i_run) begin
      // Restart the wait on every new start
      cnt_q <= '0;
      ready_q <= 1'b0;
    end else if (o_rise && !ready_q) begin
      cnt_q <= cnt_q + CNT_W'(1);
      // At or past the end, so a shorter wait written mid-count still ends it
      if (cnt_q >= i_wait - CNT_W'(1)) begin
        ready_q <= 1'b1;
      end
    end
  end

  assign o_level = sync2_q;
  assign o_rise = sync2_q & ~prev_q;
  assign o_ready = ready_q;

endmodule : scg_osc_stab
`default_nettype wire

// [scg_clock_gear.sv]
// System clock source selector, oscillator control and core clock gear
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// How it works
// [RULE1] Low osc follows enable bit outside sleep
// [RULE2] Sleep keeps low osc only if both set
// [RULE3] Reset clears low enable and rtc run
// [RULE4] Low osc clock withheld until wait elapses
// [RULE5] Crystal low wait 16384 down to 2048
// [RULE6] Internal low wait 64 down to 8
// [RULE7] Both low wait fields reset to 0x0
// [RULE8] Source 0 int high, 1 low, 2 crystal
// [RULE9] Reset runs from internal high oscillator
// [RULE10] Software enables target before selecting it
// [RULE11] Select write ignored if target not running
// [RULE12] Selected source oscillator cannot be disabled
// [RULE13] Software spaces select write and read apart
// [RULE14] Sleep exit forces internal high source
// [RULE15] Halt exit leaves oscillators and source alone
// [RULE16] Core gear divides by 1, 2, 4, 8
// [RULE17] Halt stops only the core clock
// [RULE18] Reset, NMI or interrupt ends halt
// [RULE19] Sleep stops system clock; wake restarts it
// [RULE20] Software keeps low osc on four seconds
// [RULE21] Variant bit: 1 internal, 0 crystal low
// [RULE22] Internal high enable is 1 after reset
// [RULE23] Mux switches only when both clocks low; in sleep it switches at once
module scg_clock_gear #(
  parameter logic [14:0] P_XTAL_LOW_WAIT_MIN = scg_pkg::XTAL_LOW_WAIT_MIN,  // Code 0x3 wait
  parameter logic [14:0] P_INT_LOW_WAIT_MIN = scg_pkg::INT_LOW_WAIT_MIN,    // Code 0x3 wait
  parameter logic [14:0] P_XTAL_HIGH_WAIT_MIN = scg_pkg::XTAL_HIGH_WAIT_MIN, // Code 0x3 wait
  parameter logic [14:0] P_INT_HIGH_WAIT_MIN = scg_pkg::INT_HIGH_WAIT_MIN   // Code 0x3 wait
) (
  input wire logic I_CLK_SYS, // 40 MHz system clock
  input wire logic I_RST_N, // Asynchronous reset, active low
  input wire logic [3:0] I_ADDR, // Register address
  input wire logic [7:0] I_WDATA, // Register write data
  input wire logic I_WR, // Write strobe
  input wire logic I_RD, // Read strobe
  input wire logic I_HALT_REQ, // Halt pulse from core
  input wire logic I_SLEEP_REQ, // Sleep pulse from core
  input wire logic I_IRQ, // Maskable interrupt pending
  input wire logic I_NMI, // Non-maskable interrupt pending
  input wire logic I_EXT_WAKE, // Async external wake
  input wire logic I_INT_HIGH_OSC, // Internal high osc pin
  input wire logic I_XTAL_HIGH_OSC, // Crystal high osc pin
  input wire logic I_XTAL_LOW_OSC, // Crystal low osc pin
  input wire logic I_INT_LOW_OSC, // Internal low osc pin
  output logic [7:0] O_RDATA, // Read data, cycle after strobe
  output logic O_SYS_CLK_EN, // System clock enable pulse
  output logic O_CORE_CLK_EN, // Geared core clock enable pulse
  output logic O_INT_HIGH_OSC_RUN, // Internal high osc on
  output logic O_XTAL_HIGH_OSC_RUN, // Crystal high osc on
  output logic O_XTAL_LOW_OSC_RUN, // Crystal low osc on
  output logic O_INT_LOW_OSC_RUN, // Internal low osc on
  output logic O_HALTED, // Core in halt
  output logic O_SLEEPING // Chip in sleep
);

  // Control registers
  logic ih_en_q; // internal_high_osc_enable
  logic xh_en_q; // crystal_high_osc_enable
  logic low_en_q; // low_osc_enable
  logic rtc_run_q; // rtc_run_bit
  logic [7:0] wait_q; // All four wait selects
  logic [1:0] src_q; // sys_clock_source_sel
  logic variant_q; // low_osc_variant_sel
  logic [1:0] gear_q; // core_clock_gear_sel

  // Internal state
  scg_pkg::scg_mode_t mode_q; // Run, halt or sleep
  logic [1:0] active_q; // Source the mux currently passes
  logic [2:0] gear_cnt_q; // System ticks within one core period
  logic wake1_q; // Wake synchroniser first stage
  logic wake2_q; // Wake synchroniser second stage
  logic wake3_q; // Delayed wake for edge detection

  // Oscillator status from the stabilizers
  logic ih_lvl, ih_rise, ih_rdy;
  logic xh_lvl, xh_rise, xh_rdy;
  logic low_lvl, low_rise, low_rdy;
  logic low_raw; // Pin of the chosen low speed variant
  logic [14:0] ih_wait, xh_wait, low_wait;

  // Decoded strobes and helpers
  logic sleeping;
  logic wake_rise;
  logic wr_ctrl, wr_wait, wr_src, wr_gear;
  logic [1:0] tgt; // Source named by a select write
  logic tgt_ok; // Target oscillator running and stable
  logic sel_lvl, act_lvl; // Levels of requested and active source
  logic sys_tick; // Rising edge of the active source

  assign sleeping = (mode_q == scg_pkg::ST_SLEEP);
  assign wake_rise = wake2_q & ~wake3_q;
  assign wr_ctrl = I_WR && (I_ADDR == scg_pkg::REG_OSC_CTRL);
  assign wr_wait = I_WR && (I_ADDR == scg_pkg::REG_OSC_WAIT);
  assign wr_src = I_WR && (I_ADDR == scg_pkg::REG_CLK_SRC);
  assign wr_gear = I_WR && (I_ADDR == scg_pkg::REG_CORE_GEAR);
  assign tgt = I_WDATA[scg_pkg::SRC_SEL_LSB +: 2];

  // Stabilization waits per oscillator, from the wait selects
  assign ih_wait = scg_pkg::wait_count(P_INT_HIGH_WAIT_MIN,
                                       wait_q[scg_pkg::WAIT_IH_LSB +: 2]);
  assign xh_wait = scg_pkg::wait_count(P_XTAL_HIGH_WAIT_MIN,
                                       wait_q[scg_pkg::WAIT_XH_LSB +: 2]);
  assign low_wait = variant_q ?
      scg_pkg::wait_count(P_INT_LOW_WAIT_MIN, wait_q[scg_pkg::WAIT_IL_LSB +: 2]) :  // RULE6
      scg_pkg::wait_count(P_XTAL_LOW_WAIT_MIN, wait_q[scg_pkg::WAIT_XL_LSB +: 2]);  // RULE5

  // Only the chosen variant feeds the low speed path
  assign low_raw = variant_q ? I_INT_LOW_OSC : I_XTAL_LOW_OSC;  // RULE21

  scg_osc_stab #(.CNT_W(scg_pkg::WAIT_W)) u_ih_stab (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_osc(I_INT_HIGH_OSC),
    .i_run(O_INT_HIGH_OSC_RUN),
    .i_wait(ih_wait),
    .o_level(ih_lvl),
    .o_rise(ih_rise),
    .o_ready(ih_rdy)
  );

  scg_osc_stab #(.CNT_W(scg_pkg::WAIT_W)) u_xh_stab (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_osc(I_XTAL_HIGH_OSC),
    .i_run(O_XTAL_HIGH_OSC_RUN),
    .i_wait(xh_wait),
    .o_level(xh_lvl),
    .o_rise(xh_rise),
    .o_ready(xh_rdy)
  );

  scg_osc_stab #(.CNT_W(scg_pkg::WAIT_W)) u_low_stab (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_osc(low_raw),
    .i_run(O_XTAL_LOW_OSC_RUN | O_INT_LOW_OSC_RUN),
    .i_wait(low_wait),
    .o_level(low_lvl),
    .o_rise(low_rise),
    .o_ready(low_rdy)   // RULE4
  );

  // A select write is only taken toward a running, settled oscillator
  always_comb begin
    tgt_ok = 1'b0;
    unique case (tgt)
      scg_pkg::SRC_INT_HIGH: tgt_ok = ih_rdy;
      scg_pkg::SRC_LOW: tgt_ok = low_rdy;
      scg_pkg::SRC_XTAL_HIGH: tgt_ok = xh_rdy;
      scg_pkg::SRC_RESERVED: tgt_ok = 1'b0;  // RULE8
    endcase
  end

  // Levels and edges of the requested and active sources
  always_comb begin
    sel_lvl = 1'b0;
    act_lvl = 1'b0;
    sys_tick = 1'b0;
    unique case (src_q)
      scg_pkg::SRC_LOW: sel_lvl = low_lvl;
      scg_pkg::SRC_XTAL_HIGH: sel_lvl = xh_lvl;
      default: sel_lvl = ih_lvl;  // Reserved code never stored
    endcase
    unique case (active_q)
      scg_pkg::SRC_LOW: begin
        act_lvl = low_lvl;
        sys_tick = low_rise & low_rdy;  // RULE4
      end
      scg_pkg::SRC_XTAL_HIGH: begin
        act_lvl = xh_lvl;
        sys_tick = xh_rise & xh_rdy;
      end
      default: begin
        act_lvl = ih_lvl;
        sys_tick = ih_rise & ih_rdy;
      end
    endcase
  end

  // Wake pin synchroniser
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wake1_q <= 1'b0;
      wake2_q <= 1'b0;
      wake3_q <= 1'b0;
    end else begin
      wake1_q <= I_EXT_WAKE;
      wake2_q <= wake1_q;
      wake3_q <= wake2_q;
    end
  end

  // Run, halt and sleep; reset itself also ends halt
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mode_q <= scg_pkg::ST_RUN;  // RULE18
    end else begin
      unique case (mode_q)
        scg_pkg::ST_RUN: begin
          if (I_SLEEP_REQ) begin
            mode_q <= scg_pkg::ST_SLEEP;  // RULE19
          end else if (I_HALT_REQ) begin
            mode_q <= scg_pkg::ST_HALT;  // RULE17
          end
        end
        scg_pkg::ST_HALT: begin
          if (I_IRQ || I_NMI) begin
            mode_q <= scg_pkg::ST_RUN;  // RULE18
          end
        end
        scg_pkg::ST_SLEEP: begin
          if (wake_rise) begin
            mode_q <= scg_pkg::ST_RUN;  // RULE19
          end
        end
      endcase
    end
  end

  // Oscillator control register; halt never touches it
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ih_en_q <= scg_pkg::RST_IH_EN;  // RULE22
      xh_en_q <= scg_pkg::RST_XH_EN;
      low_en_q <= scg_pkg::RST_LOW_EN;  // RULE3
      rtc_run_q <= scg_pkg::RST_RTC_RUN;  // RULE3
    end else if (sleeping && wake_rise) begin
      ih_en_q <= 1'b1;  // RULE14
    end else if (wr_ctrl) begin
      // The selected source keeps its enable set
      ih_en_q <= I_WDATA[scg_pkg::CTRL_IH_EN] | (src_q == scg_pkg::SRC_INT_HIGH);  // RULE12
      xh_en_q <= I_WDATA[scg_pkg::CTRL_XH_EN] | (src_q == scg_pkg::SRC_XTAL_HIGH);  // RULE12
      low_en_q <= I_WDATA[scg_pkg::CTRL_LOW_EN] | (src_q == scg_pkg::SRC_LOW);  // RULE1 RULE12
      rtc_run_q <= I_WDATA[scg_pkg::CTRL_RTC_RUN];
    end
  end

  // Wait selects and gear
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wait_q <= scg_pkg::RST_WAIT;  // RULE7
      gear_q <= scg_pkg::RST_GEAR;
    end else begin
      if (wr_wait) begin
        wait_q <= I_WDATA;
      end
      if (wr_gear) begin
        gear_q <= I_WDATA[1:0];
      end
    end
  end

  // Source select and variant; sleep exit falls back to internal high
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      src_q <= scg_pkg::RST_SRC;  // RULE9
      variant_q <= scg_pkg::RST_VARIANT;  // RULE21
    end else if (sleeping && wake_rise) begin
      src_q <= scg_pkg::SRC_INT_HIGH;  // RULE14
    end else if (wr_src) begin
      if (tgt_ok) begin
        src_q <= tgt;  // RULE11
      end
      // Swapping variants under a running system clock would glitch it
      if (src_q != scg_pkg::SRC_LOW) begin
        variant_q <= I_WDATA[scg_pkg::SRC_VARIANT];
      end
    end
  end

  // Mux follows the request while both clocks sit low, or at once in sleep
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      active_q <= scg_pkg::RST_SRC;
    end else if (sleeping) begin
      // No ticks in sleep, so the jump cannot cut a pulse
      active_q <= src_q;
    end else if (active_q != src_q && !act_lvl && !sel_lvl) begin
      active_q <= src_q;  // RULE23
    end
  end

  // Oscillator run outputs, gated by sleep
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_INT_HIGH_OSC_RUN <= 1'b0;
      O_XTAL_HIGH_OSC_RUN <= 1'b0;
      O_XTAL_LOW_OSC_RUN <= 1'b0;
      O_INT_LOW_OSC_RUN <= 1'b0;
    end else begin
      O_INT_HIGH_OSC_RUN <= ih_en_q & ~sleeping;
      O_XTAL_HIGH_OSC_RUN <= xh_en_q & ~sleeping;
      // Low speed survives sleep only with rtc run also set
      O_XTAL_LOW_OSC_RUN <= ~variant_q & low_en_q & (~sleeping | rtc_run_q);  // RULE1 RULE2
      O_INT_LOW_OSC_RUN <= variant_q & low_en_q & (~sleeping | rtc_run_q);  // RULE1 RULE2
    end
  end

  // System tick and geared core tick
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_SYS_CLK_EN <= 1'b0;
      O_CORE_CLK_EN <= 1'b0;
      gear_cnt_q <= 3'h0;
    end else begin
      O_SYS_CLK_EN <= sys_tick & ~sleeping;  // RULE19
      O_CORE_CLK_EN <= 1'b0;
      if (sys_tick && !sleeping) begin
        if (gear_cnt_q >= scg_pkg::gear_mask(gear_q)) begin
          gear_cnt_q <= 3'h0;
          O_CORE_CLK_EN <= (mode_q == scg_pkg::ST_RUN);  // RULE16 RULE17
        end else begin
          gear_cnt_q <= gear_cnt_q + 3'h1;  // RULE16
        end
      end
    end
  end

  // Mode status outputs
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_HALTED <= 1'b0;
      O_SLEEPING <= 1'b0;
    end else begin
      O_HALTED <= (mode_q == scg_pkg::ST_HALT);
      O_SLEEPING <= sleeping;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      unique case (I_ADDR)
        scg_pkg::REG_OSC_CTRL: O_RDATA <= {4'h0, rtc_run_q, low_en_q, xh_en_q, ih_en_q};
        scg_pkg::REG_OSC_WAIT: O_RDATA <= wait_q;
        scg_pkg::REG_CLK_SRC: O_RDATA <= {low_rdy, xh_rdy, ih_rdy, active_q, variant_q, src_q};
        scg_pkg::REG_CORE_GEAR: O_RDATA <= {6'h00, gear_q};
        default: O_RDATA <= 8'h00;  // Unmapped reads zero
      endcase
    end else begin
      O_RDATA <= 8'h00;
    end
  end

endmodule : scg_clock_gear
`default_nettype wire

// [scg_clock_gear_assertions.sv]
// Concurrent checks on the clock selector and gear top-level ports
`timescale 1ns/100ps
`default_nettype none
module scg_clock_gear_assertions (
  input wire logic I_CLK_SYS, // System clock
  input wire logic I_RST_N, // Reset, active low
  input wire logic I_HALT_REQ, // Halt pulse
  input wire logic I_SLEEP_REQ, // Sleep pulse
  input wire logic I_IRQ, // Interrupt
  input wire logic I_NMI, // Non-maskable interrupt
  input wire logic I_EXT_WAKE, // Wake line
  input wire logic O_SYS_CLK_EN, // System tick
  input wire logic O_CORE_CLK_EN, // Core tick
  input wire logic O_INT_HIGH_OSC_RUN, // Int high osc on
  input wire logic O_XTAL_LOW_OSC_RUN, // Crystal low osc on
  input wire logic O_INT_LOW_OSC_RUN, // Int low osc on
  input wire logic O_HALTED, // Halt status
  input wire logic O_SLEEPING // Sleep status
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  // Request seen while the core is running
  sequence s_run_req(req);
    req && !O_HALTED && !O_SLEEPING;
  endsequence
  // Settled modes; status and ticks are registered on the same edge, so the first status cycle already carries no tick
  sequence s_halted;
    O_HALTED && $past(O_HALTED);
  endsequence
  sequence s_asleep;
    O_SLEEPING && $past(O_SLEEPING);
  endsequence
  halt_enter_a: assert property (s_run_req(I_HALT_REQ && !I_SLEEP_REQ) |-> ##2 O_HALTED)
    else $error("no halt status");
  sleep_enter_a: assert property (s_run_req(I_SLEEP_REQ) |-> ##2 O_SLEEPING)
    else $error("no sleep status");
  halt_exit_a: assert property (O_HALTED && (I_IRQ || I_NMI) |-> ##[1:3] !O_HALTED)
    else $error("halt not ended");
  wake_exit_a: assert property (O_SLEEPING && $rose(I_EXT_WAKE) |-> ##[1:6] !O_SLEEPING)
    else $error("wake did not end sleep");
  halt_nocore_a: assert property (s_halted |-> !O_CORE_CLK_EN)
    else $error("core tick during halt");
  halt_sys_a: assert property (O_HALTED && O_SYS_CLK_EN |=> ##[0:8] (O_SYS_CLK_EN || !O_HALTED))
    else $error("no system tick in halt");
  sleep_quiet_a: assert property (s_asleep |-> !O_SYS_CLK_EN && !O_INT_HIGH_OSC_RUN)
    else $error("system clock alive in sleep");
  wake_ih_a: assert property ($fell(O_SLEEPING) |-> ##[0:3] O_INT_HIGH_OSC_RUN)
    else $error("no high osc after wake");
  low_one_a: assert property (!(O_XTAL_LOW_OSC_RUN && O_INT_LOW_OSC_RUN))
    else $error("both low osc on");
endmodule : scg_clock_gear_assertions
`default_nettype wire

// [scg_core_model.sv]
// Processor core stand-in: issues halt and sleep, measures its clock
`timescale 1ns/100ps
`default_nettype none
module scg_core_model (
  input wire logic i_clk,       // System clock
  input wire logic i_rst_n,     // Reset, active low
  input wire logic i_sys_en,    // System tick
  input wire logic i_core_en,   // Core tick
  input wire logic i_halt_cmd,  // Bench asks for halt
  input wire logic i_sleep_cmd, // Bench asks for sleep
  output logic o_halt_req,      // Halt instruction pulse
  output logic o_sleep_req,     // Sleep instruction pulse
  output logic [3:0] o_span     // System ticks per core tick
);
  logic [3:0] cnt_q; // Ticks since last core tick
  // Instruction pulses, one edge behind the command
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_halt_req <= 1'b0;
      o_sleep_req <= 1'b0;
    end else begin
      o_halt_req <= i_halt_cmd;
      o_sleep_req <= i_sleep_cmd;
    end
  end
  // Span includes the tick that ends it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 4'h0;
      o_span <= 4'h0;
    end else if (i_core_en) begin
      o_span <= cnt_q + {3'h0, i_sys_en};
      cnt_q <= 4'h0;
    end else if (i_sys_en) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : scg_core_model
`default_nettype wire

// [scg_clock_gear_tb.sv]
// Self-checking bench for the clock selector and core gear
`timescale 1ns/100ps
`default_nettype none
module scg_clock_gear_tb;
  logic clk;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, irq = 1'b0, nmi = 1'b0, wake = 1'b0;
  logic halt_cmd = 1'b0, sleep_cmd = 1'b0;
  // Oscillator pins, 4 to 6.8 cycle periods
  logic ih_osc = 1'b0, xh_osc = 1'b0, xl_osc = 1'b0, il_osc = 1'b0;
  logic [7:0] rdata;
  logic sys_en, core_en, ih_run, xh_run, xl_run, il_run, halted, sleeping;
  logic halt_req, sleep_req;
  logic [3:0] span; // Core period in system ticks
  int fail_count = 0;
  int checked = 0;
  int lo_n[2] = '{0, 0}; // Rising edges of crystal and internal low pins
  int st, n, ex;
  logic [7:0] d;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always #50 ih_osc = ~ih_osc;
  always #60 xh_osc = ~xh_osc;
  always #75 xl_osc = ~xl_osc;
  always #85 il_osc = ~il_osc;
  always @(posedge xl_osc) lo_n[0]++;
  always @(posedge il_osc) lo_n[1]++;
  // Base 2: code 3 waits 2 edges, code 0 waits 16
  scg_clock_gear #(.P_XTAL_LOW_WAIT_MIN(15'h0002), .P_INT_LOW_WAIT_MIN(15'h0002),
    .P_XTAL_HIGH_WAIT_MIN(15'h0002), .P_INT_HIGH_WAIT_MIN(15'h0002)) u_dut (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .I_HALT_REQ(halt_req), .I_SLEEP_REQ(sleep_req), .I_IRQ(irq), .I_NMI(nmi),
    .I_EXT_WAKE(wake), .I_INT_HIGH_OSC(ih_osc), .I_XTAL_HIGH_OSC(xh_osc),
    .I_XTAL_LOW_OSC(xl_osc), .I_INT_LOW_OSC(il_osc), .O_RDATA(rdata),
    .O_SYS_CLK_EN(sys_en), .O_CORE_CLK_EN(core_en), .O_INT_HIGH_OSC_RUN(ih_run),
    .O_XTAL_HIGH_OSC_RUN(xh_run), .O_XTAL_LOW_OSC_RUN(xl_run), .O_INT_LOW_OSC_RUN(il_run),
    .O_HALTED(halted), .O_SLEEPING(sleeping));
  scg_core_model u_core (.i_clk(clk), .i_rst_n(rst_n), .i_sys_en(sys_en),
    .i_core_en(core_en), .i_halt_cmd(halt_cmd), .i_sleep_cmd(sleep_cmd),
    .o_halt_req(halt_req), .o_sleep_req(sleep_req), .o_span(span));
  // Verdict and end of run
  task automatic finish_test();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // Timeout counts a mismatch, ends run
  task automatic hang();
    chk(8'h00, 8'h01, 8'hff);
    finish_test();
  endtask : hang
  task automatic chk(input logic [7:0] got, exp, m);
    checked++;
    if ((got & m) !== (exp & m)) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got & m, exp & m);
    end
  endtask : chk
  task automatic wrr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  task automatic rdd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rdd
  task automatic rc(input logic [3:0] a, input logic [7:0] exp, m);
    logic [7:0] v;
    rdd(a, v);
    chk(v, exp, m);
  endtask : rc
  // Poll source register field
  task automatic poll(input logic [7:0] m, v);
    logic [7:0] r;
    for (int t = 0; t < 300; t++) begin
      rdd(4'h2, r);
      if ((r & m) === v) return;
    end
    hang();
  endtask : poll
  task automatic wait_core(input int k);
    for (int t = 0; k > 0; t++) begin
      @(posedge clk);
      #1;
      if (core_en === 1'b1) k--;
      if (t > 400) hang();
    end
  endtask : wait_core
  task automatic wait_mode(input logic h, s);
    for (int t = 0; t < 100; t++) begin
      @(posedge clk);
      #1;
      if (halted === h && sleeping === s) return;
    end
    hang();
  endtask : wait_mode
  // Pulse: 0 halt 1 sleep 2 irq 3 nmi
  task automatic pulse(input int k);
    @(posedge clk);
    halt_cmd <= (k == 0);
    sleep_cmd <= (k == 1);
    irq <= (k == 2);
    nmi <= (k == 3);
    @(posedge clk);
    {halt_cmd, sleep_cmd, irq, nmi} <= 4'h0;
  endtask : pulse
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rc(4'h0, 8'h01, 8'hff);
    rc(4'h1, 8'h00, 8'hff);
    rc(4'h2, 8'h04, 8'h1f);
    rc(4'h3, 8'h00, 8'hff);
    rc(4'h5, 8'h00, 8'hff);
    wait_core(1);
    for (int g = 0; g < 4; g++) begin
      wrr(4'h3, 8'(g));
      wait_core(2);
      chk({4'h0, span}, 8'(1 << g), 8'hff);
    end
    wrr(4'h3, 8'h00);
    // All wait codes, both low variants
    for (int v = 0; v < 2; v++) begin
      for (int c = 0; c < 4; c++) begin
        wrr(4'h2, 8'(v * 4));
        wrr(4'h1, 8'(c << (v ? 4 : 6)));
        st = lo_n[v];
        wrr(4'h0, 8'h05);
        poll(8'h80, 8'h80);
        n = lo_n[v] - st;
        ex = 2 << (3 - c);
        chk(8'(n >= ex && n <= ex + 2), 8'h01, 8'hff);
        chk({6'h0, il_run, xl_run}, 8'(v + 1), 8'h03);
        wrr(4'h0, 8'h01);
        repeat (3) @(posedge clk);
        chk({6'h0, il_run, xl_run}, 8'h00, 8'h03);
      end
    end
    wrr(4'h2, 8'h06);
    rc(4'h2, 8'h04, 8'h07);
    wrr(4'h2, 8'h07);
    rc(4'h2, 8'h04, 8'h07);
    // Enable, select, spaced readback
    wrr(4'h0, 8'h03);
    poll(8'h40, 8'h40);
    wrr(4'h2, 8'h06);
    rc(4'h0, 8'h03, 8'h03);
    rc(4'h2, 8'h06, 8'h07);
    poll(8'h18, 8'h10);
    wrr(4'h0, 8'h01);
    rc(4'h0, 8'h03, 8'h03);
    wrr(4'h0, 8'h07);
    poll(8'h80, 8'h80);
    wrr(4'h2, 8'h05);
    rc(4'h2, 8'h05, 8'h07);
    poll(8'h18, 8'h08);
    for (int k = 2; k < 4; k++) begin
      pulse(0);
      wait_mode(1'b1, 1'b0);
      repeat (20) @(posedge clk);
      pulse(k);
      wait_mode(1'b0, 1'b0);
      rc(4'h2, 8'h05, 8'h07);
      rc(4'h0, 8'h07, 8'h07);
      wait_core(1);
    end
    // Sleep with rtc run set, then clear
    for (int r = 1; r >= 0; r--) begin
      wrr(4'h0, r ? 8'h0d : 8'h05);
      pulse(1);
      wait_mode(1'b0, 1'b1);
      repeat (3) @(posedge clk);
      chk({6'h0, xh_run, il_run}, 8'(r), 8'hff);
      @(posedge clk);
      wake <= 1'b1;
      wait_mode(1'b0, 1'b0);
      @(posedge clk);
      wake <= 1'b0;
      rc(4'h2, 8'h04, 8'h07);
      rc(4'h0, 8'h01, 8'h01);
      wait_core(1);
    end
    finish_test();
  end
endmodule : scg_clock_gear_tb
bind scg_clock_gear scg_clock_gear_assertions u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N),
  .I_HALT_REQ(I_HALT_REQ), .I_SLEEP_REQ(I_SLEEP_REQ), .I_IRQ(I_IRQ), .I_NMI(I_NMI),
  .I_EXT_WAKE(I_EXT_WAKE), .O_SYS_CLK_EN(O_SYS_CLK_EN), .O_CORE_CLK_EN(O_CORE_CLK_EN),
  .O_INT_HIGH_OSC_RUN(O_INT_HIGH_OSC_RUN), .O_XTAL_LOW_OSC_RUN(O_XTAL_LOW_OSC_RUN),
  .O_INT_LOW_OSC_RUN(O_INT_LOW_OSC_RUN), .O_HALTED(O_HALTED), .O_SLEEPING(O_SLEEPING));
`default_nettype wire
